//--- dgw_regs.svh
// Register offsets, field positions, reset values and timing counts for the glass data path
// Notes on behaviour
// (R1) Non-TFT bus width: code 00 four, 01 eight, 10 sixteen bits; 11 reserved.
// (R2) TFT display type always drives all sixteen glass data bits.
// (R3) Stagger 11: bit groups mod four delayed 0, 1/2, 1, 1 1/2 clock cycles.
// (R4) Stagger 10: even bits delayed one full clock cycle, odd bits undelayed.
// (R5) Stagger 01: odd bits delayed half a clock cycle, even bits undelayed.
// (R6) Stagger 00: all data bits launched together on one clock edge.
`ifndef DGW_REGS_SVH
`define DGW_REGS_SVH

`define DGW_CFG_ADDR      4'h0
`define DGW_CFG_RESET     16'h0000
`define DGW_CFG_WMASK     16'hf3e7
`define DGW_GWIDTH_HI     15
`define DGW_GWIDTH_LO     14
`define DGW_STAGGER_HI    13
`define DGW_STAGGER_LO    12
`define DGW_TEST_HI       9
`define DGW_TEST_LO       8
`define DGW_BPP_HI        7
`define DGW_BPP_LO        5
`define DGW_MODE_HI       2
`define DGW_MODE_LO       0
`define DGW_CLK_HZ        40000000
`define DGW_GCLK_DIV      2

`endif

//--- dgw_pkg.sv
// Types for the glass data width and stagger block
package dgw_pkg;

  typedef enum logic [1:0] {
    DGW_W4  = 2'h0,
    DGW_W8  = 2'h1,
    DGW_W16 = 2'h2,
    DGW_WRS = 2'h3
  } dgw_width_t;

  typedef enum logic [1:0] {
    DGW_STG_NONE = 2'h0,
    DGW_STG_ODD  = 2'h1,
    DGW_STG_EVEN = 2'h2,
    DGW_STG_QUAD = 2'h3
  } dgw_stagger_t;

  typedef enum logic [2:0] {
    DGW_MODE_OFF   = 3'h0,
    DGW_MODE_TFT   = 3'h1,
    DGW_MODE_MSTN  = 3'h2,
    DGW_MODE_CSTN  = 3'h3,
    DGW_MODE_RSV4  = 3'h4,
    DGW_MODE_RSV5  = 3'h5,
    DGW_MODE_RSV6  = 3'h6,
    DGW_MODE_RSV7  = 3'h7
  } dgw_mode_t;

  typedef struct packed {
    dgw_width_t   glass_width_sel;
    dgw_stagger_t data_stagger_sel;
    logic [1:0]   rsv_hi;
    logic [1:0]   test_pattern_sel;
    logic [2:0]   display_pixel_depth;
    logic [1:0]   rsv_lo;
    dgw_mode_t    display_type_sel;
  } dgw_cfg_t;

endpackage

//--- dgw_tap_delay.sv
// Selectable-depth delay line for one glass data bit
`timescale 1ns/100ps
module dgw_tap_delay
  import dgw_pkg::*;
#(
  parameter int DEPTH = 3
) (
  input  wire logic                       i_clock,
  input  wire logic                       i_nrst,
  input  wire logic                       i_d,
  input  wire logic [$clog2(DEPTH+1)-1:0] i_sel,
  output logic                            o_q
);

  logic [DEPTH-1:0] shift_r;
  logic [DEPTH:0]   taps;

  assign taps = {shift_r, i_d};

  // Shift chain
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_r <= '0;
    end else begin
      shift_r <= taps[DEPTH-1:0];
    end
  end

  // Output tap register
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_q <= 1'b0;
    end else begin
      o_q <= taps[i_sel];
    end
  end

endmodule // dgw_tap_delay

//--- dgw_top.sv
// Display config register, glass bus width and data stagger launch
`timescale 1ns/100ps
`include "dgw_regs.svh"
module dgw_top
  import dgw_pkg::*;
#(
  parameter int GCLK_DIV = `DGW_GCLK_DIV,
  parameter int DW       = 16
) (
  input  wire logic          i_clock,
  input  wire logic          i_nrst,
  input  wire logic [3:0]    i_avs_address,
  input  wire logic          i_avs_read,
  input  wire logic          i_avs_write,
  input  wire logic [31:0]   i_avs_writedata,
  input  wire logic [3:0]    i_avs_byteenable,
  output logic      [31:0]   o_avs_readdata,
  output logic               o_avs_waitrequest,
  input  wire logic [DW-1:0] i_pix_data,
  output logic               o_pix_take,
  output logic               o_graphics_clock,
  output logic      [DW-1:0] o_glass_data,
  output logic      [DW-1:0] o_glass_lane_en
);

  localparam int HALF  = (GCLK_DIV / 2 < 1) ? 1 : GCLK_DIV / 2;
  localparam int DEPTH = 3 * HALF;
  localparam int SW    = $clog2(DEPTH + 1);
  localparam int CW    = $clog2(GCLK_DIV + 1);

  dgw_cfg_t      cfg_r;
  logic          ack_r;
  logic [CW-1:0] div_r;
  logic          gclk_en;
  logic [DW-1:0] launch_r;
  logic [DW-1:0] lane_en_r;
  logic          cfg_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Half graphics clock steps for one bit
  function automatic logic [1:0] half_steps(input dgw_stagger_t stg, input int bitn);
    logic [1:0] s;
    s = 2'h0;
    unique case (stg)
      DGW_STG_QUAD: s = 2'(bitn % 4);                       // see (R3)
      DGW_STG_EVEN: s = (bitn % 2 == 0) ? 2'h2 : 2'h0;      // see (R4)
      DGW_STG_ODD:  s = (bitn % 2 == 1) ? 2'h1 : 2'h0;      // see (R5)
      DGW_STG_NONE: s = 2'h0;                               // see (R6)
    endcase
    return s;
  endfunction

  // Active glass lanes from width and type
  function automatic logic [DW-1:0] lane_mask(input dgw_width_t w, input dgw_mode_t m);
    logic [DW-1:0] k;
    k = '0;
    if (m == DGW_MODE_TFT) begin
      k = '1;                                               // see (R2)
    end else begin
      unique case (w)
        DGW_W4:  k = DW'(16'h000f);                         // see (R1)
        DGW_W8:  k = DW'(16'h00ff);                         // see (R1)
        DGW_W16: k = DW'(16'hffff);                         // see (R1)
        DGW_WRS: k = '0;                                    // see (R1)
      endcase
    end
    return k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave

  assign cfg_hit           = (i_avs_address == `DGW_CFG_ADDR);
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_r <= dgw_cfg_t'(`DGW_CFG_RESET);
    end else if (i_avs_write && !ack_r && cfg_hit) begin
      if (i_avs_byteenable[0]) begin
        cfg_r[7:0] <= i_avs_writedata[7:0] & 8'(`DGW_CFG_WMASK);
      end
      if (i_avs_byteenable[1]) begin
        cfg_r[15:8] <= i_avs_writedata[15:8] & 8'(`DGW_CFG_WMASK >> 8);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack_r) begin
      o_avs_readdata <= cfg_hit ? {16'h0000, 16'(cfg_r)} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Graphics clock divider

  assign gclk_en    = (div_r == CW'(GCLK_DIV - 1));
  assign o_pix_take = gclk_en;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      div_r <= '0;
    end else begin
      div_r <= gclk_en ? '0 : div_r + CW'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_graphics_clock <= 1'b0;
    end else begin
      o_graphics_clock <= (div_r < CW'(HALF));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Launch register and lane enables

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      launch_r  <= '0;
      lane_en_r <= '0;
    end else if (gclk_en) begin
      lane_en_r <= lane_mask(cfg_r.glass_width_sel, cfg_r.display_type_sel);
      launch_r  <= i_pix_data & lane_mask(cfg_r.glass_width_sel, cfg_r.display_type_sel);
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_glass_lane_en <= '0;
    end else begin
      o_glass_lane_en <= lane_en_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-bit stagger

  for (genvar b = 0; b < DW; b++) begin : g_bit
    logic [SW-1:0] sel;
    assign sel = SW'(half_steps(cfg_r.data_stagger_sel, b)) * SW'(HALF);
    dgw_tap_delay #(
      .DEPTH (DEPTH)
    ) u_dly (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_d     (launch_r[b]),
      .i_sel   (sel),
      .o_q     (o_glass_data[b])
    );
  end

endmodule // dgw_top

//--- dgw_top_properties.sv
// Port checker for the glass data path
`timescale 1ns/100ps
module dgw_top_properties (
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic        o_avs_waitrequest,
  input wire logic [15:0] i_pix_data,
  input wire logic        o_pix_take,
  input wire logic [15:0] o_glass_data,
  input wire logic [15:0] o_glass_lane_en
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [15:0] c_r, h_r, h1_r, h2_r, h3_r, h4_r, ln;
  logic [3:0]  n_r;
  assign ln = c_r[2:0] == 3'h1 ? 16'hffff : c_r[15:14] == 2'h0 ? 16'h000f :
              c_r[15:14] == 2'h1 ? 16'h00ff : c_r[15:14] == 2'h2 ? 16'hffff : 16'h0000;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      {c_r, h_r, h1_r, h2_r, h3_r, h4_r, n_r} <= '0;
    end else begin
      n_r <= i_avs_write ? 4'h0 : n_r + {3'h0, !n_r[3]};
      if (i_avs_write && o_avs_waitrequest && i_avs_address == 4'h0) c_r <= i_avs_writedata[15:0];
      if (o_pix_take) h_r <= i_pix_data & ln;
      {h1_r, h2_r, h3_r, h4_r} <= {h_r, h1_r, h2_r, h3_r};
    end
  end
  a_lane_mask: assert property (o_pix_take |-> ##2 o_glass_lane_en == $past(ln, 2))
    else $error("lane mask wrong");
  a_tft_lanes: assert property (o_pix_take && c_r[2:0] == 3'h1 |-> ##2 &o_glass_lane_en)
    else $error("tft lanes off");
  a_stg_none: assert property (n_r[3] && c_r[13:12] == 2'h0 |-> o_glass_data == h1_r)
    else $error("flat data wrong");
  a_stg_odd: assert property (n_r[3] && c_r[13:12] == 2'h1 |->
    o_glass_data == (h1_r & 16'h5555 | h2_r & 16'haaaa)) else $error("odd stagger wrong");
  a_stg_even: assert property (n_r[3] && c_r[13:12] == 2'h2 |->
    o_glass_data == (h3_r & 16'h5555 | h1_r & 16'haaaa)) else $error("even stagger wrong");
  a_stg_quad: assert property (n_r[3] && c_r[13:12] == 2'h3 |-> o_glass_data ==
    (h1_r & 16'h1111 | h2_r & 16'h2222 | h3_r & 16'h4444 | h4_r & 16'h8888))
    else $error("quad stagger wrong");
endmodule // dgw_top_properties
bind dgw_top dgw_top_properties chk_u (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_avs_address(i_avs_address), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_pix_data(i_pix_data), .o_pix_take(o_pix_take),
  .o_glass_data(o_glass_data), .o_glass_lane_en(o_glass_lane_en));

//--- dgw_glass_panel.sv
// Glass panel model latching the bus mid-cycle while the graphics clock is high
`timescale 1ns/100ps
module dgw_glass_panel (
  input  wire logic        i_clock,
  input  wire logic        i_graphics_clock,
  input  wire logic [15:0] i_glass_data,
  input  wire logic [15:0] i_lane_en,
  output logic      [15:0] o_word
);
  // Falling system edge keeps clear of the launch edges
  always @(negedge i_clock) begin
    if (i_graphics_clock) o_word <= i_glass_data & i_lane_en;
  end
endmodule // dgw_glass_panel

//--- dgw_top_tb.sv
// Self-checking bench for the glass data path
`timescale 1ns/100ps
module dgw_top_tb;
  logic        clk = 0, nrst = 0, rd = 0, wr = 0, wreq, take, gclk;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 0, q, rdat, v, m, s = 32'd82;
  logic [15:0] pix = 0, gd, ln;
  logic [15:0] pw, e, cfgm = 0, lm = 0, pe = 0;
  logic [15:0] lq[$];
  logic        on = 0, pv = 0;
  int          tp = -1000;
  int          n_errors = 0, check_count = 0;
  always #12.5 clk = ~clk;
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [15:0] lanes(input logic [15:0] c);
    if (c[2:0] == 3'h1) return 16'hffff;
    case (c[15:14])
      2'h0: return 16'h000f;
      2'h1: return 16'h00ff;
      2'h2: return 16'hffff;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic int stp(input logic [1:0] g, input int b);
    case (g)
      2'h3: return b % 4;
      2'h2: return (b % 2 == 0) ? 2 : 0;
      2'h1: return b % 2;
      default: return 0;
    endcase
  endfunction
  dgw_top dut_u (.i_clock(clk), .i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_pix_data(pix), .o_pix_take(take), .o_graphics_clock(gclk),
    .o_glass_data(gd), .o_glass_lane_en(ln));
  dgw_glass_panel gp_u (.i_clock(clk), .i_graphics_clock(gclk), .i_glass_data(gd),
    .i_lane_en(ln), .o_word(pw));
  always @(posedge clk) pix <= 16'(xs());
  // Launch history model, one entry a system cycle, checked between edges
  always @(negedge clk) begin
    lq.push_front(lm);
    if (lq.size() > 5) void'(lq.pop_back());
    e = 16'h0000;
    for (int b = 0; b < 16; b++) e[b] = lq[1 + stp(cfgm[13:12], b)][b];
    if (pv) chk("panel word", {16'h0000, pw}, {16'h0000, pe});
    if (gclk) begin
      pv = on;
      pe = e & lanes(cfgm);
    end
    if (on) begin
      chk("glass data", {16'h0000, gd}, {16'h0000, e});
      chk("lane enable", {16'h0000, ln}, {16'h0000, lanes(cfgm)});
    end
    if (nrst) chk("graphics clock", {31'h0, gclk}, {31'h0, take});
    if (take) begin
      if (tp > 0) chk("take period", 32'(tp), 32'd2);
      tp = 0;
      lm = pix & lanes(cfgm);
    end
    tp++;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] sn, input logic [31:0] ex);
    check_count++;
    if (sn !== ex) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 20) begin
      n_errors++;
      finish_test();
    end
    @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h0);
    chk("cfg reset", q, 32'h0);
    for (int i = 0; i < 32; i++) begin
      v = xs();
      v[15:12] = 4'(i);
      v[2:0] = i[4] ? 3'h1 : 3'h2;
      on = 1'b0;
      bus(1'b1, 4'h0, v);
      m = v & 32'h0000f3e7;
      cfgm = m[15:0];
      repeat (8) @(posedge clk);
      on = 1'b1;
      repeat (16) @(posedge clk);
      bus(1'b0, 4'h0, 32'h0);
      chk("display_config", q, m);
    end
    bus(1'b1, 4'h9, 32'hffffffff);
    bus(1'b0, 4'h9, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk("cfg kept", q, m);
    finish_test();
  end
endmodule // dgw_top_tb
